// ==== src/sbsr_consts.svh ====
// Constants for the status byte and service request block.
// Assumes inclusion by bare name from the block's design files.
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH
`define SBSR_BYTE_W 8
`define SBSR_ERRQ_DEPTH 10
`define SBSR_OUTQ_DEPTH 16
`define SBSR_MSG_W 8
`define SBSR_BIT_EVA 0
`define SBSR_BIT_ERR 2
`define SBSR_BIT_QUES 3
`define SBSR_BIT_MSG 4
`define SBSR_BIT_STD 5
`define SBSR_BIT_SUM 6
`define SBSR_BIT_OPER 7
`define SBSR_SUM_MASK 8'hBF
`define SBSR_ZERO_BYTE 8'h00
`endif

// ==== src/sbsr_pkg.sv ====
// Types shared by the status byte and service request block.
// Assumes the constants header is on the include path.
`include "sbsr_consts.svh"
package sbsr_pkg;
    typedef logic [`SBSR_BYTE_W-1:0] sbsr_byte_t;
    typedef enum logic [1:0]
    {
        SBSR_SRQ_IDLE = 2'b00,
        SBSR_SRQ_ASSERT = 2'b01
    } sbsr_srq_state_t;
endpackage

// ==== src/sbsr_fifo.sv ====
// Plain first-in first-out queue with push, pop and non-empty flag.
// Assumes pushes and pops come from logic on the same clock.
`timescale 1ns/1ps
module sbsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 10
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_data,
    output logic o_nonempty,
    output logic o_full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial
    begin
        if (DEPTH < 2 || WIDTH < 1)
            $error("sbsr_fifo: unsupported size");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_q;
    logic [AW-1:0] wr_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction
    // Full queue drops new pushes; oldest entries kept
    // A push in the clear cycle survives: set wins
    assign do_push = i_push && (i_clear || cnt_q != (AW+1)'(DEPTH));
    assign do_pop = i_pop && (cnt_q != '0);
    assign o_nonempty = (cnt_q != '0);
    assign o_full = (cnt_q == (AW+1)'(DEPTH));
    assign o_data = mem[rd_q];
    always_ff @(posedge i_clk)
    begin
        if (do_push)
            mem[i_clear ? AW'(0) : wr_q] <= i_data;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
        end
        else if (i_clear)
        begin
            rd_q <= '0;
            wr_q <= do_push ? AW'(1) : AW'(0);
            cnt_q <= do_push ? (AW+1)'(1) : (AW+1)'(0);
        end
        else
        begin
            if (do_push)
                wr_q <= next_ptr(wr_q);
            if (do_pop)
                rd_q <= next_ptr(rd_q);
            if (do_push && !do_pop)
                cnt_q <= cnt_q + (AW+1)'(1);
            else if (do_pop && !do_push)
                cnt_q <= cnt_q - (AW+1)'(1);
        end
    end
endmodule

// ==== src/sbsr_event_reg.sv ====
// Latched event register with enable mask and read-to-clear.
// Assumes condition bits and strobes are on the same clock.
`timescale 1ns/1ps
module sbsr_event_reg #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_read,
    input wire logic i_en_wr,
    input wire logic [WIDTH-1:0] i_en_data,
    output logic [WIDTH-1:0] o_event,
    output logic [WIDTH-1:0] o_enable,
    output logic o_summary
);
    initial
    begin
        if (WIDTH < 1)
            $error("sbsr_event_reg: unsupported width");
    end
    logic [WIDTH-1:0] ev_q;
    logic [WIDTH-1:0] en_q;
    // New events in the read cycle survive the clear
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ev_q <= '0;
        else if (i_read || i_clear)
            ev_q <= i_set;
        else
            ev_q <= ev_q | i_set;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            en_q <= '0;
        else if (i_en_wr)
            en_q <= i_en_data;
    end
    assign o_event = ev_q;
    assign o_enable = en_q;
    assign o_summary = |(ev_q & en_q);
endmodule

// ==== src/sbsr_top.sv ====
// Status byte, service request mask and the two message queues.
// Assumes a command parser on the same clock drives the strobes.
`timescale 1ns/1ps
`include "sbsr_consts.svh"
module sbsr_top #(
    parameter int MSG_W = `SBSR_MSG_W,
    parameter int OUTQ_DEPTH = `SBSR_OUTQ_DEPTH,
    parameter int ERRQ_DEPTH = `SBSR_ERRQ_DEPTH
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_CLR_STATUS,
    input wire logic I_RESP_PUSH,
    input wire logic [MSG_W-1:0] I_RESP_DATA,
    input wire logic I_RESP_POP,
    output logic [MSG_W-1:0] O_RESP_DATA,
    input wire logic I_ERR_PUSH,
    input wire logic [MSG_W-1:0] I_ERR_DATA,
    input wire logic I_ERR_POP,
    output logic [MSG_W-1:0] O_ERR_DATA,
    input wire logic [`SBSR_BYTE_W-1:0] I_STD_EVENT_SET,
    input wire logic I_STD_EVENT_READ,
    input wire logic I_STD_ENABLE_WR,
    input wire logic [`SBSR_BYTE_W-1:0] I_STD_ENABLE_DATA,
    output logic [`SBSR_BYTE_W-1:0] O_STD_EVENT,
    output logic [`SBSR_BYTE_W-1:0] O_STD_ENABLE,
    input wire logic I_MEAS_SUMMARY,
    input wire logic I_QUES_SUMMARY,
    input wire logic I_OPER_SUMMARY,
    input wire logic I_MASK_WR,
    input wire logic [`SBSR_BYTE_W-1:0] I_MASK_DATA,
    output sbsr_pkg::sbsr_byte_t O_MASK,
    input wire logic I_STB_QUERY,
    output sbsr_pkg::sbsr_byte_t O_STB_QUERY_DATA,
    input wire logic I_SERIAL_POLL,
    output sbsr_pkg::sbsr_byte_t O_POLL_DATA,
    output logic O_SRQ_OUT,
    output logic O_SRQ_OE,
    output logic O_QUERY_VALID,
    output logic O_POLL_VALID
);
    import sbsr_pkg::*;
    initial
    begin
        if (MSG_W < 1 || OUTQ_DEPTH < 2 || ERRQ_DEPTH < 2)
            $error("sbsr_top: unsupported parameters");
    end

    // ----------------------------------------
    // Queues
    // ----------------------------------------
    logic message_waiting_flag;
    logic error_waiting_flag;
    logic outq_full;
    logic errq_full;
    logic outq_clear;
    // Clear-status empties only the error queue; output queue survives
    assign outq_clear = 1'b0;

    sbsr_fifo #(
        .WIDTH(MSG_W),
        .DEPTH(OUTQ_DEPTH)
    ) u_outq (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_clear(outq_clear),
        .i_push(I_RESP_PUSH),
        .i_data(I_RESP_DATA),
        .i_pop(I_RESP_POP),
        .o_data(O_RESP_DATA),
        .o_nonempty(message_waiting_flag),
        .o_full(outq_full)
    );

    sbsr_fifo #(
        .WIDTH(MSG_W),
        .DEPTH(ERRQ_DEPTH)
    ) u_errq (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_clear(I_CLR_STATUS),
        .i_push(I_ERR_PUSH),
        .i_data(I_ERR_DATA),
        .i_pop(I_ERR_POP),
        .o_data(O_ERR_DATA),
        .o_nonempty(error_waiting_flag),
        .o_full(errq_full)
    );

    // ----------------------------------------
    // Standard event register
    // ----------------------------------------
    logic std_event_summary_flag;

    sbsr_event_reg #(
        .WIDTH(`SBSR_BYTE_W)
    ) u_std (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_clear(I_CLR_STATUS),
        .i_set(I_STD_EVENT_SET),
        .i_read(I_STD_EVENT_READ),
        .i_en_wr(I_STD_ENABLE_WR),
        .i_en_data(I_STD_ENABLE_DATA),
        .o_event(O_STD_EVENT),
        .o_enable(O_STD_ENABLE),
        .o_summary(std_event_summary_flag)
    );

    // ----------------------------------------
    // Status byte
    // ----------------------------------------
    sbsr_byte_t summary_bits;
    sbsr_byte_t mask_q;
    logic master_summary_flag;
    logic request_for_service_flag;
    logic [`SBSR_BYTE_W-1:0] enabled;
    logic [`SBSR_BYTE_W-1:0] enabled_prev_q;
    logic [`SBSR_BYTE_W-1:0] rising;

    // Non-latching bits straight from their sources
    always_comb
    begin
        summary_bits = `SBSR_ZERO_BYTE;
        summary_bits[`SBSR_BIT_EVA] = I_MEAS_SUMMARY;
        summary_bits[`SBSR_BIT_ERR] = error_waiting_flag;
        summary_bits[`SBSR_BIT_QUES] = I_QUES_SUMMARY;
        summary_bits[`SBSR_BIT_MSG] = message_waiting_flag;
        summary_bits[`SBSR_BIT_STD] = std_event_summary_flag;
        summary_bits[`SBSR_BIT_OPER] = I_OPER_SUMMARY;
    end

    function automatic sbsr_byte_t with_bit6(input sbsr_byte_t b, input logic v);
        sbsr_byte_t r;
        r = b;
        r[`SBSR_BIT_SUM] = v;
        return r;
    endfunction

    assign enabled = summary_bits & mask_q & `SBSR_SUM_MASK;
    assign master_summary_flag = |enabled;
    assign rising = enabled & ~enabled_prev_q;

    // ----------------------------------------
    // Mask register
    // ----------------------------------------
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
            mask_q <= `SBSR_ZERO_BYTE;
        else if (I_MASK_WR)
            mask_q <= I_MASK_DATA & `SBSR_SUM_MASK;
    end
    assign O_MASK = mask_q;

    // ----------------------------------------
    // Request for service
    // ----------------------------------------
    sbsr_srq_state_t srq_q;
    // Edge history restarts after a poll so a held event can re-request
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
            enabled_prev_q <= `SBSR_ZERO_BYTE;
        else if (I_SERIAL_POLL)
            enabled_prev_q <= `SBSR_ZERO_BYTE;
        else
            enabled_prev_q <= enabled;
    end

    // New edge during a poll wins over the poll clear
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
            srq_q <= SBSR_SRQ_IDLE;
        else
        begin
            unique case (srq_q)
                SBSR_SRQ_IDLE:
                    if (|rising)
                        srq_q <= SBSR_SRQ_ASSERT;
                SBSR_SRQ_ASSERT:
                    if ((I_SERIAL_POLL || I_CLR_STATUS) && !(|rising))
                        srq_q <= SBSR_SRQ_IDLE;
                default:
                    srq_q <= SBSR_SRQ_IDLE;
            endcase
        end
    end
    assign request_for_service_flag = (srq_q == SBSR_SRQ_ASSERT);

    // ----------------------------------------
    // Readback and request line
    // ----------------------------------------
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_STB_QUERY_DATA <= `SBSR_ZERO_BYTE;
            O_POLL_DATA <= `SBSR_ZERO_BYTE;
            O_QUERY_VALID <= 1'b0;
            O_POLL_VALID <= 1'b0;
        end
        else
        begin
            O_QUERY_VALID <= I_STB_QUERY;
            O_POLL_VALID <= I_SERIAL_POLL;
            if (I_STB_QUERY)
                O_STB_QUERY_DATA <= with_bit6(summary_bits, master_summary_flag);
            if (I_SERIAL_POLL)
                O_POLL_DATA <= with_bit6(summary_bits, request_for_service_flag);
        end
    end

    // Open-drain style: drive low only when requesting
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_SRQ_OUT <= 1'b0;
            O_SRQ_OE <= 1'b0;
        end
        else
        begin
            O_SRQ_OUT <= 1'b0;
            O_SRQ_OE <= request_for_service_flag;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_rise;
        !I_SERIAL_POLL && (|rising);
    endsequence
    sequence s_poll_quiet;
        I_SERIAL_POLL && !(|rising);
    endsequence

    AST_RISE_REQ: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_rise |=> request_for_service_flag ##1 O_SRQ_OE)
        else $error("enabled rise did not raise request");
    AST_POLL_CLR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_poll_quiet |=> !request_for_service_flag ##1 !O_SRQ_OE)
        else $error("poll did not clear request");
    AST_MSS_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_SERIAL_POLL && master_summary_flag ##1 $stable(enabled) |-> master_summary_flag)
        else $error("master summary lost on poll");
    AST_MASK_GATE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (mask_q == `SBSR_ZERO_BYTE) |-> !master_summary_flag)
        else $error("masked bits set summary");
    AST_MSG_FLAG: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_RESP_PUSH && !outq_full |=> message_waiting_flag)
        else $error("message flag not set on push");
    AST_ERR_FLAG: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_ERR_PUSH && !errq_full |=> error_waiting_flag)
        else $error("error flag not set on push");
    AST_QUERY_B6: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_STB_QUERY |=> O_QUERY_VALID
            && O_STB_QUERY_DATA[`SBSR_BIT_SUM] == $past(master_summary_flag))
        else $error("query bit6 wrong");
    AST_POLL_B6: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_SERIAL_POLL |=> O_POLL_DATA[`SBSR_BIT_SUM] == $past(request_for_service_flag))
        else $error("poll bit6 wrong");
    AST_MASK_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_MASK_WR && I_MASK_DATA == `SBSR_ZERO_BYTE |=> O_MASK == `SBSR_ZERO_BYTE)
        else $error("zero write did not clear mask");
    AST_STD_READ: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_STD_EVENT_READ && I_STD_EVENT_SET == `SBSR_ZERO_BYTE |=> !std_event_summary_flag)
        else $error("standard summary not cleared by read");

    // ----------------------------------------
    // Checks: clear, request line, queues
    // ----------------------------------------
    // Clear with no fresh edge drops the request
    sequence s_clear_quiet;
        I_CLR_STATUS && !(|rising);
    endsequence
    // Poll wipes edge history; still-enabled bit re-requests
    sequence s_poll_then_pending;
        I_SERIAL_POLL ##1 (|enabled);
    endsequence
    sequence s_hold_req;
        request_for_service_flag && !I_SERIAL_POLL && !I_CLR_STATUS;
    endsequence

    AST_REREQ: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_poll_then_pending |=> request_for_service_flag)
        else $error("pending event did not request again after poll");
    AST_CLR_RQS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_clear_quiet |=> !request_for_service_flag)
        else $error("clear-status left request flag set");
    AST_CLR_BITS: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_CLR_STATUS && !I_ERR_PUSH && (I_STD_EVENT_SET == `SBSR_ZERO_BYTE)
            |=> !error_waiting_flag && !std_event_summary_flag)
        else $error("clear-status left summary bits set");
    AST_REQ_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        s_hold_req |=> request_for_service_flag)
        else $error("request flag dropped without poll");
    AST_OE_FOLLOW: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        request_for_service_flag |=> O_SRQ_OE)
        else $error("request line not driven while flag set");
    AST_OE_DROP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !request_for_service_flag |=> !O_SRQ_OE)
        else $error("request line driven without flag");
    AST_SRQ_LOW: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        O_SRQ_OE |-> !O_SRQ_OUT)
        else $error("request line driven high");
    AST_NO_SPUR: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !request_for_service_flag && !(|rising) |=> !request_for_service_flag)
        else $error("request raised without enabled rise");
    AST_QUERY_KEEP: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_STB_QUERY && !I_SERIAL_POLL && !I_CLR_STATUS && !(|rising)
            |=> $stable(request_for_service_flag))
        else $error("query changed request flag");
    AST_POLL_VALID: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_SERIAL_POLL |=> O_POLL_VALID)
        else $error("poll answer not flagged valid");
    AST_MSG_IDLE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !message_waiting_flag && !I_RESP_PUSH |=> !message_waiting_flag)
        else $error("message flag set with no push");
    AST_ERR_IDLE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        !error_waiting_flag && !I_ERR_PUSH |=> !error_waiting_flag)
        else $error("error flag set with no push");
    AST_MASK_WRITE: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        I_MASK_WR |=> O_MASK == ($past(I_MASK_DATA) & `SBSR_SUM_MASK))
        else $error("mask write not stored");
endmodule

// ==== test/sbsr_ctrl_model.sv ====
// Bus controller model: status query, serial poll and talk reads of the queues.
// Assumes one shared clock; its strobes change at the falling edge.
`timescale 1ns/1ps
module sbsr_ctrl_model
(
    input wire logic i_clk,
    input wire logic i_query_valid,
    input wire logic i_poll_valid,
    input wire sbsr_pkg::sbsr_byte_t i_query_data,
    input wire sbsr_pkg::sbsr_byte_t i_poll_data,
    input wire logic [7:0] i_resp_data,
    input wire logic [7:0] i_err_data,
    output logic o_stb_query,
    output logic o_serial_poll,
    output logic o_resp_pop,
    output logic o_err_pop
);
    import sbsr_pkg::*;
    initial
    begin
        o_stb_query = 1'b0;
        o_serial_poll = 1'b0;
        o_resp_pop = 1'b0;
        o_err_pop = 1'b0;
    end
    // ------------------------------------------------
    // Requests
    // ------------------------------------------------
    // One-cycle strobe; bounded wait so a dead answer cannot hang the run
    task automatic ask(input bit poll, output sbsr_byte_t d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge i_clk);
        o_serial_poll = poll;
        o_stb_query = !poll;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(negedge i_clk);
            o_serial_poll = 1'b0;
            o_stb_query = 1'b0;
            ok = (poll ? i_poll_valid : i_query_valid) === 1'b1;
            d = poll ? i_poll_data : i_query_data;
        end
    endtask
    // Talk read: head word taken, then popped
    task automatic talk(input bit err, output logic [7:0] d);
        @(negedge i_clk);
        d = err ? i_err_data : i_resp_data;
        o_err_pop = err;
        o_resp_pop = !err;
        @(negedge i_clk);
        o_err_pop = 1'b0;
        o_resp_pop = 1'b0;
    endtask
endmodule

// ==== test/sbsr_top_bench.sv ====
// Self-checking bench for the status byte and service request block.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ps
`include "sbsr_consts.svh"
module sbsr_top_bench;
    import sbsr_pkg::*;
    logic clk, rst, clr, rpush, rpop, epush, epop, stdrd, stdwr, meas, ques, oper, mwr;
    logic [7:0] rdat, edat, stdset, stddat, mdat, ro, eo, sev, sen, d, m;
    logic stbq, spoll, qv, pv, srq_out, srq_oe;
    sbsr_byte_t mo, qd, pd;
    logic [7:0] q[$];
    int err_total, num_checks;
    wire srq_line = srq_oe ? srq_out : 1'b1; // Pulled up when released
    sbsr_top dut
    (
        .I_CLK_SYS(clk), .I_RST(rst), .I_CLR_STATUS(clr),
        .I_RESP_PUSH(rpush), .I_RESP_DATA(rdat), .I_RESP_POP(rpop), .O_RESP_DATA(ro),
        .I_ERR_PUSH(epush), .I_ERR_DATA(edat), .I_ERR_POP(epop), .O_ERR_DATA(eo),
        .I_STD_EVENT_SET(stdset), .I_STD_EVENT_READ(stdrd), .I_STD_ENABLE_WR(stdwr),
        .I_STD_ENABLE_DATA(stddat), .O_STD_EVENT(sev), .O_STD_ENABLE(sen),
        .I_MEAS_SUMMARY(meas), .I_QUES_SUMMARY(ques), .I_OPER_SUMMARY(oper),
        .I_MASK_WR(mwr), .I_MASK_DATA(mdat), .O_MASK(mo),
        .I_STB_QUERY(stbq), .O_STB_QUERY_DATA(qd), .I_SERIAL_POLL(spoll), .O_POLL_DATA(pd),
        .O_SRQ_OUT(srq_out), .O_SRQ_OE(srq_oe), .O_QUERY_VALID(qv), .O_POLL_VALID(pv)
    );
    sbsr_ctrl_model ctrl
    (
        .i_clk(clk), .i_query_valid(qv), .i_poll_valid(pv), .i_query_data(qd),
        .i_poll_data(pd), .i_resp_data(ro), .i_err_data(eo), .o_stb_query(stbq),
        .o_serial_poll(spoll), .o_resp_pop(rpop), .o_err_pop(epop)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string s);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, s, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic ask(input bit poll, output logic [7:0] v);
        bit ok;
        ctrl.ask(poll, v, ok);
        if (!ok)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: no answer", $time);
            print_verdict();
        end
    endtask
    task automatic push(input bit er, input logic [7:0] v);
        @(negedge clk);
        epush = er;
        rpush = !er;
        edat = v;
        rdat = v;
        @(negedge clk);
        {epush, rpush} = 2'b00;
    endtask
    // Kinds: 0 clear-status, 1 event read, 2 event set, 3 event enable, 4 mask write
    task automatic strobe(input int k, input logic [7:0] v);
        @(negedge clk);
        case (k)
            0: clr = 1'b1;
            1: stdrd = 1'b1;
            2: stdset = v;
            3: stdwr = 1'b1;
            default: mwr = 1'b1;
        endcase
        stddat = v;
        mdat = v;
        @(negedge clk);
        {clr, stdrd, stdwr, mwr} = 4'h0;
        stdset = 8'h00;
    endtask
    function automatic logic [7:0] exp_stb(input logic [7:0] k, input logic mg, input logic er,
        input logic sd);
        logic [7:0] b;
        b = 8'h00;
        b[`SBSR_BIT_EVA] = meas;
        b[`SBSR_BIT_ERR] = er;
        b[`SBSR_BIT_QUES] = ques;
        b[`SBSR_BIT_MSG] = mg;
        b[`SBSR_BIT_STD] = sd;
        b[`SBSR_BIT_OPER] = oper;
        b[`SBSR_BIT_SUM] = |(b & k & `SBSR_SUM_MASK);
        return b;
    endfunction
    // ------------------------------------------------
    // Tests
    // ------------------------------------------------
    initial
    begin
        {clr, rpush, epush, stdrd, stdwr, meas, ques, oper, mwr} = '0;
        {rdat, edat, stdset, stddat, mdat} = '0;
        err_total = 0;
        num_checks = 0;
        rst = 1'b1;
        void'($urandom(38));
        tick(8);
        rst = 1'b0;
        ask(0, d);
        check(d, 8'h00, "query after reset");
        check(mo, 8'h00, "mask after reset");
        ask(1, d);
        check(d, 8'h00, "poll after reset");
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            @(negedge clk);
            {meas, ques, oper} = 3'($urandom);
            m = (i < 2) ? {8{i[0]}} : 8'($urandom);
            strobe(4, m);
            tick(2);
            m = m & `SBSR_SUM_MASK;
            check(mo, m, "mask readback");
            ask(0, d);
            check(d, exp_stb(m, 0, 0, 0), "status query");
            ask(0, d);
            check(d, exp_stb(m, 0, 0, 0), "repeat query");
        end
        {meas, ques, oper} = 3'b000;
        strobe(4, 8'h00);
        tick(2);
        ask(1, d);
        check(mo, 8'h00, "zero write clears mask");
        $display("test random summary done");
        for (int i = 0; i < 3; i++)
        begin
            q.push_back(8'($urandom));
            push(0, q[i]);
        end
        tick(2);
        ask(0, d);
        check(d, 8'h10, "message flag set");
        foreach (q[i])
        begin
            ctrl.talk(0, d);
            check(d, q[i], "response order");
        end
        tick(2);
        ask(0, d);
        check(d, 8'h00, "message flag clear");
        q.delete();
        for (int i = 0; i <= `SBSR_ERRQ_DEPTH; i++)
        begin
            q.push_back(8'($urandom));
            push(1, q[i]);
        end
        tick(2);
        ask(0, d);
        check(d, 8'h04, "error flag set");
        for (int i = 0; i < `SBSR_ERRQ_DEPTH; i++)
        begin
            ctrl.talk(1, d);
            check(d, q[i], "error order");
        end
        tick(2);
        ask(0, d);
        check(d, 8'h00, "eleventh entry dropped");
        $display("test queues done");
        strobe(4, 8'h10);
        push(0, 8'h5A);
        tick(4);
        check(8'(srq_line), 8'h00, "request asserted");
        ask(1, d);
        check(d, 8'h50, "poll carries request");
        tick(4);
        check(8'(srq_line), 8'h00, "pending event requests again");
        ask(0, d);
        check(d, 8'h50, "summary survives poll");
        strobe(4, 8'h00);
        tick(2);
        check(8'(srq_line), 8'h00, "line held until poll");
        ask(1, d);
        check(d, 8'h50, "request still flagged");
        tick(3);
        check(8'(srq_line), 8'h01, "line released by poll");
        ask(0, d);
        check(d, 8'h10, "masked summary");
        ctrl.talk(0, d);
        check(d, 8'h5A, "response after request");
        $display("test service request done");
        strobe(3, 8'h24);
        for (int i = 0; i < 2; i++)
        begin
            m = i ? 8'h03 : (8'($urandom) | 8'h04);
            strobe(2, m);
            tick(2);
            check(sen, 8'h24, "event enable");
            check(sev, m, "events latched");
            ask(0, d);
            check(d, exp_stb(0, 0, 0, |(m & 8'h24)), "event summary");
            strobe(1, 8'h00);
            tick(2);
            check(sev, 8'h00, "read clears events");
            ask(0, d);
            check(d, 8'h00, "summary drops after read");
        end
        strobe(4, 8'h20);
        push(0, 8'h33);
        push(1, 8'h44);
        strobe(2, 8'h04);
        strobe(0, 8'h00);
        tick(2);
        check(8'(srq_line), 8'h01, "clear drops request line");
        ask(0, d);
        check(d, 8'h10, "clear keeps only message flag");
        check(sev, 8'h00, "clear empties events");
        ask(1, d);
        check(d, 8'h10, "clear resets request flag");
        $display("test events and clear done");
        print_verdict();
    end
endmodule
